// ### core/sics_consts.vh
// Constants of the secure install command sequencer.
// Assumes byte framing, status codes and operation codes shared with the engine that does the work.
`ifndef SICS_CONSTS_VH
`define SICS_CONSTS_VH
// Framing bytes
`define SICS_CMD_START 8'h01
`define SICS_DATA_START 8'h81
`define SICS_END_MARK 8'h03
`define SICS_RSP_OK 8'h1a
`define SICS_RSP_ERR 8'h9a
`define SICS_CMD_CODE 8'h28
`define SICS_REPLY_LEN 8'h0a
`define SICS_REPLY_BYTES 4'hf
`define SICS_ALL_ONES 32'hffffffff
// Packet lengths (length field values)
`define SICS_CMD_LEN 16'h0001
`define SICS_PAR_LEN 16'h0041
`define SICS_KEY_LEN 16'h0031
`define SICS_NONCE_LEN 16'h001d
`define SICS_DATA_MIN 16'h0021
`define SICS_DATA_MAX 16'h0411
// Status codes
`define SICS_ST_OK 8'h00
`define SICS_ST_PKT 8'hc1
`define SICS_ST_SUM 8'hc2
`define SICS_ST_ACC 8'hc3
`define SICS_ST_SEC 8'hc4
`define SICS_ST_PROT 8'hc5
`define SICS_ST_FLASH 8'hc6
`define SICS_ST_TSYS 8'hc7
`define SICS_ST_PARAM 8'hc8
`define SICS_ST_HW 8'hc9
`define SICS_ST_ADDR 8'hca
`define SICS_ST_VERIFY 8'hcb
// Operation codes for the worker engine
`define SICS_OP_ERASE 4'h1
`define SICS_OP_DEC_PAR 4'h2
`define SICS_OP_KEY_DIS 4'h3
`define SICS_OP_KEY_WRAP 4'h4
`define SICS_OP_KEY_STORE 4'h5
`define SICS_OP_PL_CHG 4'h6
`define SICS_OP_INIT_DEC 4'h7
`define SICS_OP_DEC_DATA 4'h8
`define SICS_OP_WRITE 4'h9
`define SICS_OP_LCK_TRANS 4'ha
`endif

// ### core/sics_sequencer.v
// Secure install command sequencer: packet parser, checks, operation sequencing, status replies.
// Assumes an external engine performs erase, crypto and flash work and reports done/fail.
// Function
// - Success reply is 81,00,0A,1A,00, eight FF bytes, E4, 03.
// - Error reply uses same framing, code 9A, status, detail, address, computed checksum.
// - Bytes are discarded until the start byte arrives; then the packet begins.
// - Missing end marker gives packet error and nothing further is done.
// - Checksum mismatch gives checksum error and return to command wait.
// - Length bytes wrong for format or command give packet error and abort.
// - Forbidden lifecycle state or no reset since data write gives acceptance error.
// - Authentication level one or zero gives secure error.
// - Boot flag not set, or in dual-bank mode bank swap fields not 111b, give protection error.
// - Any permanent block protect bit at zero gives protection error.
// - Erase user and data areas; flash access error on failure, else OK.
// - Decrypt parameter packet; trusted error on failure, silence if subsystem abnormal.
// - Unspecified parameter gives parameter error; disabled locked boot gives protection error.
// - Disable level-one key, or both keys for locked boot; failure gives flash error.
// - Level-two path: OK, receive key, wrap then store, trusted or flash errors.
// - Change protection level; flash error on failure, hardware error and silence if invalid.
// - Nonce packet initialises decryption; OK, trusted error, or silence if abnormal.
// - Decrypted data with bad size, range, unit or alignment gives parameter error.
// - Boundary-blocked range gives invalid address error; locked area gives protection error.
// - Non-last data packet: OK first, then write; flash error on write failure.
// - Config area writes are read back; mismatch gives verify error.
// - Last packet: write, locked boot transition if asked, hardware error or OK.
// - Data packet wrong reply code gives packet error; excess total gives parameter error.
`timescale 1ns/1ns
`include "sics_consts.vh"

module sics_sequencer #(
  parameter PBP_W = 32,
  parameter CMD_LEN = `SICS_CMD_LEN,
  parameter PAR_LEN = `SICS_PAR_LEN
) (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Received byte stream
  input wire [7:0] rx_byte_in,
  input wire rx_valid_in,
  // Transmitted byte stream
  output reg [7:0] tx_byte_out,
  output reg tx_valid_out,
  input wire tx_ready_in,
  // Payload bytes to the worker engine
  output reg [7:0] pl_byte_out,
  output reg pl_valid_out,
  // Worker engine handshake
  output reg op_req_out,
  output reg [3:0] op_code_out,
  input wire op_done_in,
  input wire op_fail_in,
  input wire [31:0] op_status_in,
  input wire tsys_abnormal_in,
  input wire verify_fail_in,
  input wire level_invalid_in,
  // Device state for acceptance
  input wire lifecycle_ok_in,
  input wire auth_level_low_in,
  input wire boot_flag_bit_in,
  input wire dual_bank_in,
  input wire [2:0] bank_swap_select_in,
  input wire [2:0] secure_bank_swap_select_in,
  input wire [PBP_W-1:0] permanent_block_protect_in,
  input wire [PBP_W-1:0] secure_permanent_block_protect_in,
  // Decrypted parameter and data checks
  input wire param_unspecified_in,
  input wire locked_boot_req_in,
  input wire lck_disabled_in,
  input wire chk_param_err_in,
  input wire chk_addr_err_in,
  input wire chk_lock_err_in,
  input wire [31:0] announced_data_length_in,
  // Status
  output reg unresponsive_out,
  output reg [2:0] stage_out
);

  localparam S_RX = 3'h0;
  localparam S_CHK = 3'h1;
  localparam S_OP = 3'h2;
  localparam S_TX = 3'h3;
  localparam S_DEAD = 3'h4;

  localparam STG_CMD = 3'h0;
  localparam STG_PAR = 3'h1;
  localparam STG_KEY = 3'h2;
  localparam STG_NONCE = 3'h3;
  localparam STG_DATA = 3'h4;

  localparam NXT_RX = 2'h0;
  localparam NXT_WRITE = 2'h1;
  localparam NXT_DEAD = 2'h2;

  reg [2:0] state;
  reg [2:0] phase;
  reg [15:0] len;
  reg [15:0] cnt;
  reg [7:0] sum;
  reg sum_ok;
  reg end_ok;
  reg code_ok;
  reg [31:0] total;
  reg [3:0] cur_op;
  reg [7:0] rsp;
  reg [7:0] scode;
  reg [31:0] det;
  reg [3:0] tx_idx;
  reg [1:0] after_tx;
  reg wrote_data;
  reg lck_req;
  reg last;

  wire [7:0] start_byte = (stage_out == STG_CMD) ? `SICS_CMD_START : `SICS_DATA_START;
  wire [7:0] first_byte = (stage_out == STG_CMD) ? `SICS_CMD_CODE : `SICS_RSP_OK;
  wire [15:0] exp_len = (stage_out == STG_CMD) ? CMD_LEN[15:0] :
                        (stage_out == STG_PAR) ? PAR_LEN[15:0] :
                        (stage_out == STG_KEY) ? `SICS_KEY_LEN : `SICS_NONCE_LEN;
  wire [15:0] data_n = len - 16'h0001;
  wire len_good = (stage_out == STG_DATA) ?
                  (len >= `SICS_DATA_MIN && len <= `SICS_DATA_MAX && data_n[3:0] == 4'h0) :
                  (len == exp_len);
  wire [31:0] new_total = total + {16'h0000, data_n};
  wire [7:0] next_sum = sum + rx_byte_in;
  wire pbp_open = (&permanent_block_protect_in) & (&secure_permanent_block_protect_in);
  wire bank_bad = dual_bank_in && (bank_swap_select_in != 3'h7 || secure_bank_swap_select_in != 3'h7);
  wire [7:0] body_sum = `SICS_REPLY_LEN + rsp + scode + det[31:24] + det[23:16] + det[15:8] + det[7:0]
                        + 8'hff + 8'hff + 8'hff + 8'hff;
  wire [7:0] reply_sum = 8'h00 - body_sum;

  ////////////////////////////////////////////////////////////////////////////
  // Reply byte selection
  function [7:0] reply_byte;
    input [3:0] i;
    begin
      case (i)
        4'h0: reply_byte = `SICS_DATA_START;
        4'h1: reply_byte = 8'h00;
        4'h2: reply_byte = `SICS_REPLY_LEN;
        4'h3: reply_byte = rsp;
        4'h4: reply_byte = scode;
        4'h5: reply_byte = det[31:24];
        4'h6: reply_byte = det[23:16];
        4'h7: reply_byte = det[15:8];
        4'h8: reply_byte = det[7:0];
        4'hd: reply_byte = reply_sum;
        4'he: reply_byte = `SICS_END_MARK;
        default: reply_byte = 8'hff;
      endcase
    end
  endfunction

  task send;
    input [7:0] code;
    input [31:0] detail;
    input [1:0] nxt;
    begin
      rsp <= (code == `SICS_ST_OK) ? `SICS_RSP_OK : `SICS_RSP_ERR;
      scode <= code;
      det <= detail;
      tx_idx <= 4'h0;
      after_tx <= nxt;
      state <= S_TX;
      if (code != `SICS_ST_OK) begin
        stage_out <= STG_CMD;
      end
    end
  endtask

  task start_op;
    input [3:0] op;
    begin
      op_req_out <= 1'b1;
      op_code_out <= op;
      cur_op <= op;
      state <= S_OP;
      if (op == `SICS_OP_WRITE) begin
        wrote_data <= 1'b1;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= S_RX;
      stage_out <= STG_CMD;
      phase <= 3'h0;
      len <= 16'h0000;
      cnt <= 16'h0000;
      sum <= 8'h00;
      sum_ok <= 1'b0;
      end_ok <= 1'b0;
      code_ok <= 1'b0;
      total <= 32'h00000000;
      cur_op <= 4'h0;
      rsp <= 8'h00;
      scode <= 8'h00;
      det <= 32'h00000000;
      tx_idx <= 4'h0;
      after_tx <= NXT_RX;
      wrote_data <= 1'b0;
      lck_req <= 1'b0;
      last <= 1'b0;
      tx_byte_out <= 8'h00;
      tx_valid_out <= 1'b0;
      pl_byte_out <= 8'h00;
      pl_valid_out <= 1'b0;
      op_req_out <= 1'b0;
      op_code_out <= 4'h0;
      unresponsive_out <= 1'b0;
    end else begin
      op_req_out <= 1'b0;
      pl_valid_out <= 1'b0;
      unresponsive_out <= (state == S_DEAD);
      case (state)
        S_RX: begin
          if (rx_valid_in) begin
            case (phase)
              3'h0: begin
                if (rx_byte_in == start_byte) begin
                  phase <= 3'h1;
                end
              end
              3'h1: begin
                len[15:8] <= rx_byte_in;
                sum <= rx_byte_in;
                code_ok <= 1'b0;
                phase <= 3'h2;
              end
              3'h2: begin
                len[7:0] <= rx_byte_in;
                sum <= next_sum;
                cnt <= 16'h0000;
                phase <= ({len[15:8], rx_byte_in} == 16'h0000) ? 3'h4 : 3'h3;
              end
              3'h3: begin
                if (cnt == 16'h0000) begin
                  code_ok <= (rx_byte_in == first_byte);
                end
                pl_byte_out <= rx_byte_in;
                pl_valid_out <= 1'b1;
                sum <= next_sum;
                cnt <= cnt + 16'h0001;
                if (cnt + 16'h0001 == len) begin
                  phase <= 3'h4;
                end
              end
              3'h4: begin
                sum_ok <= (next_sum == 8'h00);
                phase <= 3'h5;
              end
              default: begin
                end_ok <= (rx_byte_in == `SICS_END_MARK);
                phase <= 3'h0;
                state <= S_CHK;
              end
            endcase
          end
        end
        S_CHK: begin
          if (!end_ok) begin
            send(`SICS_ST_PKT, `SICS_ALL_ONES, NXT_RX);
          end else if (!sum_ok) begin
            send(`SICS_ST_SUM, `SICS_ALL_ONES, NXT_RX);
          end else if (len == 16'h0000 || !len_good) begin
            send(`SICS_ST_PKT, `SICS_ALL_ONES, NXT_RX);
          end else if (!code_ok) begin
            send(`SICS_ST_PKT, `SICS_ALL_ONES, NXT_RX);
          end else if (stage_out == STG_DATA && new_total > announced_data_length_in) begin
            send(`SICS_ST_PARAM, `SICS_ALL_ONES, NXT_RX);
          end else begin
            case (stage_out)
              STG_CMD: begin
                if (!lifecycle_ok_in || wrote_data) begin
                  send(`SICS_ST_ACC, `SICS_ALL_ONES, NXT_RX);
                end else if (auth_level_low_in) begin
                  send(`SICS_ST_SEC, `SICS_ALL_ONES, NXT_RX);
                end else if (!boot_flag_bit_in || bank_bad) begin
                  send(`SICS_ST_PROT, `SICS_ALL_ONES, NXT_RX);
                end else if (!pbp_open) begin
                  send(`SICS_ST_PROT, `SICS_ALL_ONES, NXT_RX);
                end else begin
                  start_op(`SICS_OP_ERASE);
                end
              end
              STG_PAR: start_op(`SICS_OP_DEC_PAR);
              STG_KEY: start_op(`SICS_OP_KEY_WRAP);
              STG_NONCE: start_op(`SICS_OP_INIT_DEC);
              default: begin
                total <= new_total;
                last <= (new_total == announced_data_length_in);
                start_op(`SICS_OP_DEC_DATA);
              end
            endcase
          end
        end
        S_OP: begin
          if (op_done_in) begin
            case (cur_op)
              `SICS_OP_ERASE: begin
                if (op_fail_in) begin
                  send(`SICS_ST_FLASH, op_status_in, NXT_RX);
                end else begin
                  stage_out <= STG_PAR;
                  send(`SICS_ST_OK, `SICS_ALL_ONES, NXT_RX);
                end
              end
              `SICS_OP_DEC_PAR, `SICS_OP_KEY_WRAP, `SICS_OP_INIT_DEC, `SICS_OP_DEC_DATA: begin
                if (tsys_abnormal_in) begin
                  state <= S_DEAD;
                end else if (op_fail_in) begin
                  send(`SICS_ST_TSYS, `SICS_ALL_ONES, NXT_RX);
                end else if (cur_op == `SICS_OP_DEC_PAR) begin
                  if (param_unspecified_in) begin
                    send(`SICS_ST_PARAM, `SICS_ALL_ONES, NXT_RX);
                  end else if (locked_boot_req_in && lck_disabled_in) begin
                    send(`SICS_ST_PROT, `SICS_ALL_ONES, NXT_RX);
                  end else begin
                    lck_req <= locked_boot_req_in;
                    start_op(`SICS_OP_KEY_DIS);
                  end
                end else if (cur_op == `SICS_OP_KEY_WRAP) begin
                  start_op(`SICS_OP_KEY_STORE);
                end else if (cur_op == `SICS_OP_INIT_DEC) begin
                  stage_out <= STG_DATA;
                  total <= 32'h00000000;
                  send(`SICS_ST_OK, `SICS_ALL_ONES, NXT_RX);
                end else if (chk_param_err_in) begin
                  send(`SICS_ST_PARAM, `SICS_ALL_ONES, NXT_RX);
                end else if (chk_addr_err_in) begin
                  send(`SICS_ST_ADDR, `SICS_ALL_ONES, NXT_RX);
                end else if (chk_lock_err_in) begin
                  send(`SICS_ST_PROT, `SICS_ALL_ONES, NXT_RX);
                end else if (last) begin
                  start_op(`SICS_OP_WRITE);
                end else begin
                  send(`SICS_ST_OK, `SICS_ALL_ONES, NXT_WRITE);
                end
              end
              `SICS_OP_KEY_DIS, `SICS_OP_KEY_STORE: begin
                if (op_fail_in) begin
                  send(`SICS_ST_FLASH, op_status_in, NXT_RX);
                end else if (lck_req || cur_op == `SICS_OP_KEY_STORE) begin
                  start_op(`SICS_OP_PL_CHG);
                end else begin
                  stage_out <= STG_KEY;
                  send(`SICS_ST_OK, `SICS_ALL_ONES, NXT_RX);
                end
              end
              `SICS_OP_WRITE: begin
                if (op_fail_in) begin
                  send(`SICS_ST_FLASH, op_status_in, NXT_RX);
                end else if (verify_fail_in) begin
                  send(`SICS_ST_VERIFY, `SICS_ALL_ONES, NXT_RX);
                end else if (!last) begin
                  state <= S_RX;
                end else if (lck_req) begin
                  start_op(`SICS_OP_LCK_TRANS);
                end else begin
                  stage_out <= STG_CMD;
                  send(`SICS_ST_OK, `SICS_ALL_ONES, NXT_RX);
                end
              end
              default: begin
                if (op_fail_in) begin
                  send(`SICS_ST_FLASH, op_status_in, NXT_RX);
                end else if (level_invalid_in) begin
                  send(`SICS_ST_HW, `SICS_ALL_ONES, NXT_DEAD);
                end else begin
                  stage_out <= (cur_op == `SICS_OP_PL_CHG) ? STG_NONCE : STG_CMD;
                  send(`SICS_ST_OK, `SICS_ALL_ONES, NXT_RX);
                end
              end
            endcase
          end
        end
        S_TX: begin
          if (tx_valid_out && tx_ready_in) begin
            tx_valid_out <= 1'b0;
          end
          if (!tx_valid_out || tx_ready_in) begin
            if (tx_idx == `SICS_REPLY_BYTES) begin
              if (after_tx == NXT_WRITE) begin
                start_op(`SICS_OP_WRITE);
              end else if (after_tx == NXT_DEAD) begin
                state <= S_DEAD;
              end else begin
                state <= S_RX;
              end
            end else begin
              tx_byte_out <= reply_byte(tx_idx);
              tx_valid_out <= 1'b1;
              tx_idx <= tx_idx + 4'h1;
            end
          end
        end
        default: state <= S_DEAD;
      endcase
    end
  end

endmodule

// ### bench/sics_chk.sv
// Checker of the reply frames and operation requests of the sequencer.
// Assumes it is bound to sics_sequencer and that a reply frame has 15 bytes.
`timescale 1ns/1ns
module sics_chk (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Watched ports
  input wire [7:0] tx_byte_out,
  input wire tx_valid_out,
  input wire tx_ready_in,
  input wire op_req_out,
  input wire [3:0] op_code_out,
  input wire unresponsive_out
);
  reg [3:0] idx;
  reg [7:0] sum;
  reg ok_reply;
  wire acc = tx_valid_out && tx_ready_in;
  wire [7:0] tot = sum + tx_byte_out;
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idx <= 4'h0;
      sum <= 8'h00;
      ok_reply <= 1'b0;
    end else if (acc) begin
      idx <= (idx == 4'he) ? 4'h0 : idx + 4'h1;
      sum <= (idx == 4'h0) ? 8'h00 : tot;
      if (idx == 4'h3)
        ok_reply <= (tx_byte_out == 8'h1a);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_code;
    acc && idx == 4'h3;
  endsequence
  sequence s_fill;
    acc && idx > 4'h4 && idx < 4'hd;
  endsequence
  a_reply_start: assert property (acc && idx == 4'h0 |-> tx_byte_out == 8'h81)
    else $error("reply start byte wrong");
  a_byte_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
    else $error("reply byte not held");
  a_frame_fixed: assert property (acc && (idx == 4'h1 || idx == 4'h2 || idx == 4'he) |->
    tx_byte_out == ((idx == 4'h1) ? 8'h00 : (idx == 4'h2) ? 8'h0a : 8'h03)) else $error("frame byte wrong");
  a_reply_code: assert property (s_code |-> tx_byte_out == 8'h1a || tx_byte_out == 8'h9a)
    else $error("reply code wrong");
  a_ok_status: assert property (acc && idx == 4'h4 |-> (tx_byte_out == 8'h00) == ok_reply)
    else $error("status does not match reply code");
  a_ok_fill: assert property (s_fill ##0 ok_reply |-> tx_byte_out == 8'hff)
    else $error("ok reply field not all ones");
  a_addr_ones: assert property (acc && idx > 4'h8 && idx < 4'hd |-> tx_byte_out == 8'hff)
    else $error("failure address not all ones");
  a_sum_zero: assert property (acc && idx == 4'hd |-> tot == 8'h00)
    else $error("reply checksum wrong");
  a_ok_sum: assert property (acc && ok_reply && idx == 4'hd |-> tx_byte_out == 8'he4)
    else $error("ok reply checksum wrong");
  a_dead_quiet: assert property (unresponsive_out |-> !tx_valid_out && !op_req_out)
    else $error("activity after going silent");
  a_write_quiet: assert property (op_req_out && op_code_out == 4'h9 |-> !tx_valid_out)
    else $error("write requested during reply");
endmodule

// ### bench/sics_host.sv
// Host tool model: sends framed packets on the byte stream and collects replies.
// Assumes one received byte a cycle and a 15-byte reply frame.
`timescale 1ns/1ns
module sics_host (
  // Clock
  input wire clk_in,
  // Stream towards the device
  output reg [7:0] rx_byte_out,
  output reg rx_valid_out,
  // Stream from the device
  input wire [7:0] tx_byte_in,
  input wire tx_valid_in,
  output reg tx_ready_out
);
  reg [7:0] rep [0:14];
  integer nrep = 0;
  reg slow = 1'b0;
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
  end
  always @(posedge clk_in) begin
    tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
    if (tx_valid_in && tx_ready_out) begin
      if (nrep < 15)
        rep[nrep] <= tx_byte_in;
      nrep <= nrep + 1;
    end
  end
  task put(input [7:0] b);
    begin
      @(posedge clk_in);
      rx_byte_out <= b;
      rx_valid_out <= 1'b1;
    end
  endtask
  task send(input [7:0] st, input [15:0] len, input [7:0] code, input integer nb, input bad_sum, input no_end);
    reg [7:0] s;
    integer i;
    begin
      s = len[15:8] + len[7:0] + code;
      put(~st);
      put(st); // Noise before the start byte is skipped
      put(len[15:8]);
      put(len[7:0]);
      put(code);
      for (i = 0; i < nb; i = i + 1) begin
        put(i[7:0]);
        s = s + i[7:0];
      end
      put(bad_sum ? 8'h01 - s : 8'h00 - s);
      put(no_end ? 8'h55 : 8'h03);
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_byte_out <= ~rx_byte_out;
    end
  endtask
endmodule

// ### bench/sics_sequencer_tb.sv
// Self-checking bench of the sequencer with a host model and an engine model.
// Assumes the checker and host model files are compiled before this one.
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t mismatch %h %h", $time, a, e); end end
module sics_sequencer_tb;
  reg clk_in = 1'b0;
  reg sys_rst_in = 1'b1;
  wire [7:0] rx_b, tx_b, pl_b;
  wire rx_v, tx_v, tx_r, op_req, dead, pl_v;
  wire [3:0] op_code;
  wire [2:0] stage;
  reg op_done = 1'b0;
  reg [31:0] op_st = 32'h5a5a1234;
  reg [3:0] fop, top, vop, lop;
  reg lc_ok, a_low, bflag, dual, p_un, t_lck, l_dis, c_p, c_a, c_l, got;
  reg [2:0] swp, sswp;
  reg [31:0] pbp, spbp, ann;
  reg [47:0] oplog = 48'h0;
  reg [1:0] dly = 2'h0;
  integer n_mismatch = 0, total_checks = 0, k, p, npl = 0;
  // Row: fault kind, failing operation, silent flag, expected status (ff: no reply)
  reg [23:0] rows [0:32] = '{24'h000000, 24'h0100c3, 24'h0200c4, 24'h0300c5, 24'h0400c5, 24'h0500c5,
    24'h0600c5, 24'h0010c6, 24'h0701ff, 24'h0020c7, 24'h0800c8, 24'h0900c5, 24'h0030c6, 24'h0040c7,
    24'h0050c6, 24'h0060c6, 24'h0a01c9, 24'h0070c7, 24'h0080c7, 24'h0b00c8, 24'h0c00ca, 24'h0d00c5,
    24'h0090c6, 24'h0e00cb, 24'h0f0000, 24'h0fa0c6, 24'h1001c9, 24'h1100c1, 24'h1200c2, 24'h1300c1,
    24'h1400c1, 24'h1500c1, 24'h1600c8};
  always #10 clk_in = ~clk_in;
  sics_sequencer uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rx_byte_in(rx_b), .rx_valid_in(rx_v),
    .tx_byte_out(tx_b), .tx_valid_out(tx_v), .tx_ready_in(tx_r), .pl_byte_out(pl_b), .pl_valid_out(pl_v),
    .op_req_out(op_req), .op_code_out(op_code), .op_done_in(op_done), .op_fail_in(op_code === fop),
    .op_status_in(op_st), .tsys_abnormal_in(op_code === top), .verify_fail_in(op_code === vop),
    .level_invalid_in(op_code === lop), .lifecycle_ok_in(lc_ok), .auth_level_low_in(a_low),
    .boot_flag_bit_in(bflag), .dual_bank_in(dual), .bank_swap_select_in(swp), .secure_bank_swap_select_in(sswp),
    .permanent_block_protect_in(pbp), .secure_permanent_block_protect_in(spbp), .param_unspecified_in(p_un),
    .locked_boot_req_in(t_lck), .lck_disabled_in(l_dis), .chk_param_err_in(c_p), .chk_addr_err_in(c_a),
    .chk_lock_err_in(c_l), .announced_data_length_in(ann), .unresponsive_out(dead), .stage_out(stage));
  sics_host h (.clk_in(clk_in), .rx_byte_out(rx_b), .rx_valid_out(rx_v), .tx_byte_in(tx_b),
    .tx_valid_in(tx_v), .tx_ready_out(tx_r));
  ////////////////////////////////////////////////////////////////////////////////
  // Engine model: completes each operation four cycles after its request
  always @(posedge clk_in) begin
    op_done <= 1'b0;
    if (pl_v) npl <= npl + 1;
    if (op_req) begin
      dly <= 2'h3;
      oplog <= {oplog[43:0], op_code};
    end else if (dly != 2'h0) begin
      dly <= dly - 2'h1;
      op_done <= (dly == 2'h1);
    end
  end
  task stop_test;
    begin
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task wait_reply;
    integer i;
    begin
      got = 1'b0;
      for (i = 0; i < 300 && !got; i = i + 1) begin
        @(posedge clk_in);
        #1 got = (h.nrep == 15);
      end
    end
  endtask
  task chk_reply(input [7:0] st, input [31:0] det);
    reg [7:0] e [0:14];
    reg [7:0] s;
    integer i;
    begin
      e[0] = 8'h81; e[1] = 8'h00; e[2] = 8'h0a; e[3] = (st == 8'h00) ? 8'h1a : 8'h9a; e[4] = st;
      s = e[2] + e[3] + st + 8'hfc;
      for (i = 0; i < 4; i = i + 1) begin
        e[5 + i] = det[31 - 8 * i -: 8];
        e[9 + i] = 8'hff;
        s = s + e[5 + i];
      end
      e[13] = 8'h00 - s; e[14] = 8'h03;
      for (i = 0; i < 15; i = i + 1) `CHK(h.rep[i], e[i])
    end
  endtask
  task cmd_try(input [7:0] st);
    begin
      h.nrep = 0;
      npl = 0;
      h.send(8'h01, 16'h0001, 8'h28, 0, 1'b0, 1'b0);
      wait_reply;
      chk_reply(st, 32'hffffffff);
      `CHK({npl[7:0], pl_b}, 16'h0128)
    end
  endtask
  task run_row(input [23:0] r);
    reg [7:0] cd;
    reg [15:0] ln;
    begin
      fop <= r[15:12]; top <= 4'h0; vop <= 4'h0; lop <= 4'h0; lc_ok <= 1'b1; a_low <= 1'b0; bflag <= 1'b1;
      dual <= 1'b0; swp <= 3'h7; sswp <= 3'h7; pbp <= 32'hffffffff; spbp <= 32'hffffffff; ann <= 32'h40;
      p_un <= 1'b0; t_lck <= 1'b0; l_dis <= 1'b0; c_p <= 1'b0; c_a <= 1'b0; c_l <= 1'b0;
      case (r[23:16])
        8'h01: lc_ok <= 1'b0;
        8'h02: a_low <= 1'b1;
        8'h03: bflag <= 1'b0;
        8'h04: begin dual <= 1'b1; sswp <= 3'h6; end
        8'h05: pbp <= 32'hfffffffe;
        8'h06: spbp <= 32'h7fffffff;
        8'h07: top <= 4'h2;
        8'h08: p_un <= 1'b1;
        8'h09: begin t_lck <= 1'b1; l_dis <= 1'b1; end
        8'h0a: lop <= 4'h6;
        8'h0b: c_p <= 1'b1;
        8'h0c: c_a <= 1'b1;
        8'h0d: c_l <= 1'b1;
        8'h0e: vop <= 4'h9;
        8'h0f: t_lck <= 1'b1;
        8'h10: begin t_lck <= 1'b1; lop <= 4'ha; end
        8'h16: ann <= 32'h10;
        default: ;
      endcase
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      oplog = 48'h0;
      p = 0;
      while (p < 6) begin
        ln = (p == 0) ? 16'h0001 : (p == 1) ? 16'h0041 : (p == 2) ? 16'h0031 : (p == 3) ? 16'h001d : 16'h0021;
        cd = (p == 0) ? ((r[23:16] == 8'h14) ? 8'h27 : 8'h28) : (p == 4 && r[23:16] == 8'h15) ? 8'h1b : 8'h1a;
        if (p == 0 && r[23:16] == 8'h13) ln = 16'h0002;
        h.nrep = 0;
        h.send((p == 0) ? 8'h01 : 8'h81, ln, cd, ln - 1, p == 0 && r[23:16] == 8'h12, p == 0 && r[23:16] == 8'h11);
        wait_reply;
        if (!got || h.rep[4] !== 8'h00) p = 9;
        else p = (p == 1 && t_lck) ? 3 : p + 1; // Key packet only without locked boot
        if (p == 5) begin
          h.nrep = 0; // A write fault answers after the early OK
          repeat (40) @(posedge clk_in);
          if (h.nrep != 0) begin
            wait_reply;
            p = 9;
          end
        end
        repeat (8) @(posedge clk_in);
      end
      if (r[7:0] == 8'hff) `CHK(got, 1'b0)
      else if (!got) begin n_mismatch++; stop_test; end
      else chk_reply(r[7:0], (r[7:0] == 8'hc6) ? op_st : 32'hffffffff);
      if (r[8]) `CHK(dead, 1'b1)
      else `CHK(stage, 3'h0)
      if (r[7:0] == 8'h00) `CHK(oplog, t_lck ? 48'h00123678989a : 48'h012345678989)
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    `CHK({tx_v, op_req, dead, stage}, 6'h00)
    run_row(24'h000000);
    for (k = 0; k < 33; k = k + 1) begin
      h.slow <= k[0];
      run_row(rows[k]);
    end
    run_row(24'h000000);
    cmd_try(8'hc3);
    sys_rst_in <= 1'b1;
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    cmd_try(8'h00);
    stop_test;
  end
endmodule
bind sics_sequencer sics_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .tx_byte_out(tx_byte_out),
  .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .op_req_out(op_req_out), .op_code_out(op_code_out),
  .unresponsive_out(unresponsive_out));
